/* core/rotate_sub_skip_regs.vh */
// Register offsets, field positions, opcodes and reset values
// Assumes a 32-bit AHB-Lite slave port and one system clock
`ifndef ROTATE_SUB_SKIP_REGS_VH
`define ROTATE_SUB_SKIP_REGS_VH

`define OFF_CTRL    8'h00
`define OFF_ACC     8'h04
`define OFF_MEM     8'h08
`define OFF_IMM     8'h0c
`define OFF_FLAGS   8'h10
`define OFF_TPTR    8'h14
`define OFF_THIGH   8'h18
`define OFF_PAGE    8'h1c
`define OFF_STATUS  8'h20

`define CTRL_OP_HI  4
`define CTRL_OP_LO  0
`define CTRL_BIT_HI 7
`define CTRL_BIT_LO 5

`define FLAG_C      0
`define FLAG_AUX    1
`define FLAG_Z      2
`define FLAG_OVF    3

`define ST_BUSY     0
`define ST_SKIP     1
`define ST_DUMMY    2

`define RST_BYTE    8'h00
`define RST_PAGE    3'h0
`define LAST_PAGE   3'h7
`define ALL_ONES    8'hff
`define ONE_BYTE    8'h01

`define HTRANS_NSEQ 2'h2
`define HTRANS_SEQ  2'h3

`define OP_ROT_LC_MEM    5'h00
`define OP_ROT_LC_ACC    5'h01
`define OP_ROT_R_MEM     5'h02
`define OP_ROT_R_ACC     5'h03
`define OP_ROT_RC_MEM    5'h04
`define OP_ROT_RC_ACC    5'h05
`define OP_SUBB_ACC      5'h06
`define OP_SUBB_MEM      5'h07
`define OP_SUB           5'h08
`define OP_SUB_MEM       5'h09
`define OP_SUBI          5'h0a
`define OP_DEC_SKIP      5'h0b
`define OP_DEC_SKIP_ACC  5'h0c
`define OP_INC_SKIP      5'h0d
`define OP_INC_SKIP_ACC  5'h0e
`define OP_SNZB          5'h0f
`define OP_SKIP_ZERO     5'h10
`define OP_SKIP_ZERO_ACC 5'h11
`define OP_SZB           5'h12
`define OP_SET           5'h13
`define OP_SETB          5'h14
`define OP_SWAP          5'h15
`define OP_SWAP_ACC      5'h16
`define OP_TABC          5'h17
`define OP_TABL          5'h18
`define OP_XOR           5'h19
`define OP_XOR_MEM       5'h1a
`define OP_XORI          5'h1b

`endif

/* core/mcu_rotate_sub_skip_exec.v */
// Execution datapath for rotate, subtract, skip, set, swap, table read, XOR
// Assumes an AHB-Lite master with single word transfers and a program
// memory that answers rom_data within the same clock as rom_addr.
// Functional notes
// - Memory rotate left through carry, write back
// - Rotate left through carry into accumulator
// - Memory circular rotate right, no flags
// - Circular rotate right into accumulator, no flags
// - Rotate right through carry, only carry changes
// - Subtract with borrow, four flags updated
// - Carry cleared on borrow, else set
// - Plain subtract from memory or immediate
// - Decrement memory, skip if zero
// - Decrement into accumulator, skip if zero
// - Increment memory, skip if zero
// - Increment into accumulator, skip if zero
// - Skip when selected bit is one
// - Skip when selected bit is zero
// - Skip on zero byte, optional move
// - Skips take two cycles with dummy
// - Byte set all ones, bit set
// - Nibble swap to memory or accumulator
// - Table read current or last page
// - XOR to accumulator or memory, zero flag
`timescale 1ns/1ps
`include "rotate_sub_skip_regs.vh"

module mcu_rotate_sub_skip_exec (
	input  wire        clock,
	input  wire        rst_n,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire        hready,
	input  wire [31:0] hwdata,
	output reg  [31:0] hrdata,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [10:0] rom_addr,
	input  wire [15:0] rom_data,
	output reg         skip_next,
	output reg         dummy_cycle
);

	localparam [1:0] S_IDLE  = 2'h0;
	localparam [1:0] S_EXEC  = 2'h1;
	localparam [1:0] S_DUMMY = 2'h2;
	localparam [1:0] S_TABLE = 2'h3;

	reg [1:0] state;
	reg [4:0] op;
	reg [2:0] bit_sel;
	reg [7:0] acc;
	reg [7:0] mem;
	reg [7:0] imm;
	reg       flag_c;
	reg       flag_ac;
	reg       flag_z;
	reg       flag_ov;
	reg [7:0] table_pointer;
	reg [7:0] table_high_byte_holder;
	reg [2:0] page;
	reg       wr_pend;
	reg [7:0] wr_addr;

	reg [7:0] next_acc;
	reg [7:0] next_mem;
	reg       next_c;
	reg       next_ac;
	reg       next_z;
	reg       next_ov;
	reg       is_skip;
	reg       skip_cond;
	reg       is_table;

	wire       busy = (state != S_IDLE);
	wire       addr_ok = hsel & hready & (htrans == `HTRANS_NSEQ || htrans == `HTRANS_SEQ);
	wire [7:0] sub_b = (op == `OP_SUBI) ? imm : mem;
	wire       sub_cin = (op == `OP_SUBB_ACC || op == `OP_SUBB_MEM) ? flag_c : 1'b1;
	wire [8:0] sub_sum = {1'b0, acc} + {1'b0, ~sub_b} + {8'h00, sub_cin};
	wire [4:0] sub_nib = {1'b0, acc[3:0]} + {1'b0, ~sub_b[3:0]} + {4'h0, sub_cin};
	wire [7:0] xor_b = (op == `OP_XORI) ? imm : mem;
	wire [7:0] xor_r = acc ^ xor_b;
	wire [7:0] dec_r = mem - `ONE_BYTE;
	wire [7:0] inc_r = mem + `ONE_BYTE;
	wire [7:0] bit_mask = `ONE_BYTE << bit_sel;
	wire       sel_bit = mem[bit_sel];

	// Slave never stalls, so every response is zero-wait OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;

	always @*
	begin
		next_acc  = acc;
		next_mem  = mem;
		next_c    = flag_c;
		next_ac   = flag_ac;
		next_z    = flag_z;
		next_ov   = flag_ov;
		is_skip   = 1'b0;
		skip_cond = 1'b0;
		is_table  = 1'b0;
		case (op)
			`OP_ROT_LC_MEM:
			begin
				next_mem = {mem[6:0], flag_c};
				next_c   = mem[7];
			end
			`OP_ROT_LC_ACC:
			begin
				next_acc = {mem[6:0], flag_c};
				next_c   = mem[7];
			end
			`OP_ROT_R_MEM:
			begin
				next_mem = {mem[0], mem[7:1]};
			end
			`OP_ROT_R_ACC:
			begin
				next_acc = {mem[0], mem[7:1]};
			end
			`OP_ROT_RC_MEM:
			begin
				next_mem = {flag_c, mem[7:1]};
				next_c   = mem[0];
			end
			`OP_ROT_RC_ACC:
			begin
				next_acc = {flag_c, mem[7:1]};
				next_c   = mem[0];
			end
			`OP_SUBB_ACC, `OP_SUBB_MEM, `OP_SUB, `OP_SUB_MEM, `OP_SUBI:
			begin
				if (op == `OP_SUBB_MEM || op == `OP_SUB_MEM)
					next_mem = sub_sum[7:0];
				else
					next_acc = sub_sum[7:0];
				// Carry out of acc + ~b + cin is the no-borrow indication
				next_c  = sub_sum[8];
				next_ac = sub_nib[4];
				next_z  = (sub_sum[7:0] == `RST_BYTE);
				next_ov = (acc[7] ^ sub_b[7]) & (sub_sum[7] ^ acc[7]);
			end
			`OP_DEC_SKIP:
			begin
				next_mem  = dec_r;
				is_skip   = 1'b1;
				skip_cond = (dec_r == `RST_BYTE);
			end
			`OP_DEC_SKIP_ACC:
			begin
				next_acc  = dec_r;
				is_skip   = 1'b1;
				skip_cond = (dec_r == `RST_BYTE);
			end
			`OP_INC_SKIP:
			begin
				next_mem  = inc_r;
				is_skip   = 1'b1;
				skip_cond = (inc_r == `RST_BYTE);
			end
			`OP_INC_SKIP_ACC:
			begin
				next_acc  = inc_r;
				is_skip   = 1'b1;
				skip_cond = (inc_r == `RST_BYTE);
			end
			`OP_SNZB:
			begin
				is_skip   = 1'b1;
				skip_cond = sel_bit;
			end
			`OP_SZB:
			begin
				is_skip   = 1'b1;
				skip_cond = ~sel_bit;
			end
			`OP_SKIP_ZERO:
			begin
				is_skip   = 1'b1;
				skip_cond = (mem == `RST_BYTE);
			end
			`OP_SKIP_ZERO_ACC:
			begin
				next_acc  = mem;
				is_skip   = 1'b1;
				skip_cond = (mem == `RST_BYTE);
			end
			`OP_SET:
			begin
				next_mem = `ALL_ONES;
			end
			`OP_SETB:
			begin
				next_mem = mem | bit_mask;
			end
			`OP_SWAP:
			begin
				next_mem = {mem[3:0], mem[7:4]};
			end
			`OP_SWAP_ACC:
			begin
				next_acc = {mem[3:0], mem[7:4]};
			end
			`OP_TABC, `OP_TABL:
			begin
				// Operands stay put; the program word lands one state later
				is_table = 1'b1;
			end
			`OP_XOR, `OP_XORI:
			begin
				next_acc = xor_r;
				next_z   = (xor_r == `RST_BYTE);
			end
			`OP_XOR_MEM:
			begin
				next_mem = xor_r;
				next_z   = (xor_r == `RST_BYTE);
			end
			default:
			begin
				// Unused codes run as a one-cycle no-op
				next_acc = acc;
			end
		endcase
	end

	always @(posedge clock)
	begin
		if (!rst_n)
		begin
			state                  <= S_IDLE;
			op                     <= `OP_ROT_LC_MEM;
			bit_sel                <= 3'h0;
			acc                    <= `RST_BYTE;
			mem                    <= `RST_BYTE;
			imm                    <= `RST_BYTE;
			flag_c                 <= 1'b0;
			flag_ac                <= 1'b0;
			flag_z                 <= 1'b0;
			flag_ov                <= 1'b0;
			table_pointer          <= `RST_BYTE;
			table_high_byte_holder <= `RST_BYTE;
			page                   <= `RST_PAGE;
			wr_pend                <= 1'b0;
			wr_addr                <= `RST_BYTE;
			hrdata                 <= 32'h0000_0000;
			rom_addr               <= 11'h000;
			skip_next              <= 1'b0;
			dummy_cycle            <= 1'b0;
		end
		else
		begin
			wr_pend <= addr_ok & hwrite;
			if (addr_ok)
			begin
				wr_addr <= haddr[7:0];
			end
			// Read data is captured at the address phase; single transfers
			// only, so a preceding write has always landed by then
			if (addr_ok && !hwrite)
			begin
				case (haddr[7:0])
					`OFF_ACC:    hrdata <= {24'h000000, acc};
					`OFF_MEM:    hrdata <= {24'h000000, mem};
					`OFF_IMM:    hrdata <= {24'h000000, imm};
					`OFF_FLAGS:  hrdata <= {28'h0000000, flag_ov, flag_z, flag_ac, flag_c};
					`OFF_TPTR:   hrdata <= {24'h000000, table_pointer};
					`OFF_THIGH:  hrdata <= {24'h000000, table_high_byte_holder};
					`OFF_PAGE:   hrdata <= {29'h0, page};
					`OFF_STATUS: hrdata <= {29'h0, dummy_cycle, skip_next, busy};
					default:     hrdata <= 32'h0000_0000;
				endcase
			end
			// Writes while an operation runs are dropped to keep operands stable
			if (wr_pend && !busy)
			begin
				case (wr_addr)
					`OFF_CTRL:
					begin
						op        <= hwdata[`CTRL_OP_HI:`CTRL_OP_LO];
						bit_sel   <= hwdata[`CTRL_BIT_HI:`CTRL_BIT_LO];
						skip_next <= 1'b0;
						state     <= S_EXEC;
					end
					`OFF_ACC:
					begin
						acc <= hwdata[7:0];
					end
					`OFF_MEM:
					begin
						mem <= hwdata[7:0];
					end
					`OFF_IMM:
					begin
						imm <= hwdata[7:0];
					end
					`OFF_FLAGS:
					begin
						flag_c  <= hwdata[`FLAG_C];
						flag_ac <= hwdata[`FLAG_AUX];
						flag_z  <= hwdata[`FLAG_Z];
						flag_ov <= hwdata[`FLAG_OVF];
					end
					`OFF_TPTR:
					begin
						table_pointer <= hwdata[7:0];
					end
					`OFF_PAGE:
					begin
						page <= hwdata[2:0];
					end
					default:
					begin
						// High byte holder is read-only, so its writes fall here
						op <= op;
					end
				endcase
			end
			case (state)
				S_IDLE:
				begin
					dummy_cycle <= 1'b0;
				end
				S_EXEC:
				begin
					acc     <= next_acc;
					mem     <= next_mem;
					flag_c  <= next_c;
					flag_ac <= next_ac;
					flag_z  <= next_z;
					flag_ov <= next_ov;
					if (is_skip)
					begin
						skip_next   <= skip_cond;
						dummy_cycle <= 1'b1;
						state       <= S_DUMMY;
					end
					else if (is_table)
					begin
						// Last page is the top 256 words of program memory
						rom_addr <= {(op == `OP_TABL) ? `LAST_PAGE : page, table_pointer};
						state    <= S_TABLE;
					end
					else
					begin
						state <= S_IDLE;
					end
				end
				S_DUMMY:
				begin
					dummy_cycle <= 1'b0;
					state       <= S_IDLE;
				end
				S_TABLE:
				begin
					mem                    <= rom_data[7:0];
					table_high_byte_holder <= rom_data[15:8];
					state                  <= S_IDLE;
				end
				default:
				begin
					state <= S_IDLE;
				end
			endcase
		end
	end

endmodule // mcu_rotate_sub_skip_exec

/* sim/exec_chk_sva.sv */
// Checker for the execution block, sees top ports only
// Assumes one clock, single AHB transfers, no write while busy
`timescale 1ns/1ps
module exec_chk (
	input wire        clock,
	input wire        rst_n,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hwdata,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire [10:0] rom_addr,
	input wire        skip_next,
	input wire        dummy_cycle
);
	reg  wr_q;
	wire rd_ap    = hsel && hready && htrans[1] && !hwrite;
	wire skip_wr  = wr_q && hwdata[4:0] >= 5'h0b && hwdata[4:0] <= 5'h12;
	wire plain_wr = wr_q && !skip_wr;
	wire last_wr  = wr_q && hwdata[4:0] == 5'h18;
	// Data phase of a control write, when the op code stands on hwdata
	always @(posedge clock)
		wr_q <= rst_n && hsel && hready && htrans[1] && hwrite && haddr[7:0] == 8'h00;
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);
	bus_okay_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
	dummy_start_a: assert property (skip_wr |-> ##2 dummy_cycle) else $error("no dummy cycle");
	dummy_one_a: assert property (dummy_cycle |=> !dummy_cycle) else $error("dummy too long");
	no_dummy_a: assert property (plain_wr |-> ##1 !dummy_cycle ##1 !dummy_cycle) else $error("stray dummy");
	dummy_cause_a: assert property ($rose(dummy_cycle) |-> $past(skip_wr, 2)) else $error("dummy uncaused");
	skip_set_a: assert property ($rose(skip_next) |-> dummy_cycle) else $error("skip without dummy");
	skip_clear_a: assert property ($fell(skip_next) |-> $past(wr_q) || $past(wr_q, 2)) else $error("skip lost");
	last_page_a: assert property (last_wr |-> ##2 rom_addr[10:8] == 3'h7) else $error("not last page");
	rom_hold_a: assert property ($changed(rom_addr) |-> $past(wr_q, 2)) else $error("rom moved");
	rd_hold_a: assert property ($changed(hrdata) |-> $past(rd_ap)) else $error("read data moved");
	cover property (skip_wr);
	cover property (last_wr);
	cover property ($rose(skip_next));
endmodule // exec_chk
bind mcu_rotate_sub_skip_exec exec_chk exec_chk_i (.clock(clock), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .rom_addr(rom_addr), .skip_next(skip_next), .dummy_cycle(dummy_cycle));

/* sim/mcu_rotate_sub_skip_exec_tb_top.sv */
// Testbench: runs each op through AHB register tasks and checks results
// Assumes a one-cycle data phase and a ROM answering combinationally
`timescale 1ns/1ps
module mcu_rotate_sub_skip_exec_tb_top;
	logic        clock, rst_n, hsel, hwrite;
	logic [31:0] haddr, hwdata, d;
	logic [1:0]  htrans;
	wire  [31:0] hrdata;
	wire         hreadyout, hresp, skip_next, dummy_cycle;
	wire  [10:0] rom_addr;
	// High byte flags the pointer, low byte the page, so both halves are told apart
	wire  [15:0] rom_data = {~rom_addr[7:0], 5'h00, rom_addr[10:8]};
	int          n_mismatch, n_checks;
	mcu_rotate_sub_skip_exec mcu_rotate_sub_skip_exec_i (.clock(clock), .rst_n(rst_n), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rom_addr(rom_addr), .rom_data(rom_data),
		.skip_next(skip_next), .dummy_cycle(dummy_cycle));
	task give_verdict;
	begin
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	end
	endtask
	task chk(input [31:0] g, input [31:0] e);
	begin
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	end
	endtask
	// Waits for an edge with hready high, bounded
	task wt;
		int k;
	begin
		k = 0;
		@(posedge clock);
		while (hreadyout !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				n_mismatch++;
				give_verdict;
			end
			@(posedge clock);
		end
	end
	endtask
	task wr(input [7:0] a, input [31:0] v);
	begin
		haddr <= {24'h0, a};
		hwrite <= 1'b1;
		htrans <= 2'h2;
		wt;
		htrans <= 2'h0;
		hwdata <= v;
		wt;
	end
	endtask
	task rd(input [7:0] a, output [31:0] v);
	begin
		haddr <= {24'h0, a};
		hwrite <= 1'b0;
		htrans <= 2'h2;
		wt;
		htrans <= 2'h0;
		wt;
		v = hrdata;
	end
	endtask
	// Loads operands, runs one op, polls busy, checks status, skip, acc, mem and flags
	task t(input [4:0] op, input [2:0] b, input [7:0] a, m, input [3:0] f, input [7:0] ea, em,
		input [3:0] ef, input es);
		int n;
	begin
		wr(8'h04, {24'h0, a});
		wr(8'h08, {24'h0, m});
		wr(8'h10, {28'h0, f});
		wr(8'h00, {24'h0, b, op});
		n = 0;
		rd(8'h20, d);
		while (d[0] !== 1'b0)
		begin
			n++;
			if (n > 10)
			begin
				n_mismatch++;
				give_verdict;
			end
			rd(8'h20, d);
		end
		chk(d, {29'h0, es, 2'h0} >> 1);
		chk({31'h0, skip_next}, {31'h0, es});
		rd(8'h04, d);
		chk(d, {24'h0, ea});
		rd(8'h08, d);
		chk(d, {24'h0, em});
		rd(8'h10, d);
		chk(d, {28'h0, ef});
		$display("test op %h done", op);
	end
	endtask
	initial
	begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	initial
	begin
		rst_n = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		htrans = 2'h0;
		haddr = 32'h0;
		hwdata = 32'h0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		@(posedge clock);
		wr(8'h0c, 32'h21);
		t(5'h00, 3'h0, 8'h11, 8'h81, 4'h0, 8'h11, 8'h02, 4'h1, 1'b0);
		t(5'h01, 3'h0, 8'h00, 8'h40, 4'hd, 8'h81, 8'h40, 4'hc, 1'b0);
		t(5'h02, 3'h0, 8'h22, 8'h01, 4'h5, 8'h22, 8'h80, 4'h5, 1'b0);
		t(5'h03, 3'h0, 8'h22, 8'h02, 4'ha, 8'h01, 8'h02, 4'ha, 1'b0);
		t(5'h04, 3'h0, 8'h22, 8'h01, 4'h6, 8'h22, 8'h00, 4'h7, 1'b0);
		t(5'h05, 3'h0, 8'h22, 8'h02, 4'h1, 8'h81, 8'h02, 4'h0, 1'b0);
		t(5'h06, 3'h0, 8'h10, 8'h01, 4'h0, 8'h0e, 8'h01, 4'h1, 1'b0);
		t(5'h07, 3'h0, 8'h80, 8'h01, 4'h1, 8'h80, 8'h7f, 4'h9, 1'b0);
		t(5'h08, 3'h0, 8'h05, 8'h05, 4'h0, 8'h00, 8'h05, 4'h7, 1'b0);
		t(5'h09, 3'h0, 8'h00, 8'h01, 4'hf, 8'h00, 8'hff, 4'h0, 1'b0);
		t(5'h0a, 3'h0, 8'h20, 8'h33, 4'h0, 8'hff, 8'h33, 4'h0, 1'b0);
		t(5'h0b, 3'h0, 8'h22, 8'h01, 4'h5, 8'h22, 8'h00, 4'h5, 1'b1);
		t(5'h0c, 3'h0, 8'h22, 8'h00, 4'h0, 8'hff, 8'h00, 4'h0, 1'b0);
		t(5'h0d, 3'h0, 8'h22, 8'hff, 4'h0, 8'h22, 8'h00, 4'h0, 1'b1);
		t(5'h0e, 3'h0, 8'h22, 8'h10, 4'h0, 8'h11, 8'h10, 4'h0, 1'b0);
		t(5'h0f, 3'h7, 8'h22, 8'h80, 4'h0, 8'h22, 8'h80, 4'h0, 1'b1);
		t(5'h10, 3'h0, 8'h22, 8'h00, 4'h0, 8'h22, 8'h00, 4'h0, 1'b1);
		t(5'h11, 3'h0, 8'h22, 8'h5a, 4'h0, 8'h5a, 8'h5a, 4'h0, 1'b0);
		t(5'h12, 3'h3, 8'h22, 8'hf7, 4'h0, 8'h22, 8'hf7, 4'h0, 1'b1);
		t(5'h12, 3'h0, 8'h22, 8'h01, 4'h0, 8'h22, 8'h01, 4'h0, 1'b0);
		t(5'h13, 3'h0, 8'h22, 8'h12, 4'h0, 8'h22, 8'hff, 4'h0, 1'b0);
		t(5'h14, 3'h5, 8'h22, 8'h00, 4'h0, 8'h22, 8'h20, 4'h0, 1'b0);
		t(5'h15, 3'h0, 8'h22, 8'h12, 4'h0, 8'h22, 8'h21, 4'h0, 1'b0);
		t(5'h16, 3'h0, 8'h22, 8'h34, 4'h0, 8'h43, 8'h34, 4'h0, 1'b0);
		t(5'h19, 3'h0, 8'h0f, 8'hff, 4'hf, 8'hf0, 8'hff, 4'hb, 1'b0);
		t(5'h1a, 3'h0, 8'haa, 8'haa, 4'h0, 8'haa, 8'h00, 4'h4, 1'b0);
		t(5'h1b, 3'h0, 8'h21, 8'h00, 4'h1, 8'h00, 8'h00, 4'h5, 1'b0);
		wr(8'h1c, 32'h3);
		wr(8'h14, 32'h3c);
		t(5'h17, 3'h0, 8'h22, 8'h00, 4'h0, 8'h22, 8'h03, 4'h0, 1'b0);
		rd(8'h18, d);
		chk(d, 32'hc3);
		t(5'h18, 3'h0, 8'h22, 8'h00, 4'h0, 8'h22, 8'h07, 4'h0, 1'b0);
		wr(8'h18, 32'h0);
		rd(8'h18, d);
		chk(d, 32'hc3);
		wr(8'h30, 32'hffffffff);
		rd(8'h30, d);
		chk(d, 32'h0);
		$display("test map done");
		give_verdict;
	end
endmodule // mcu_rotate_sub_skip_exec_tb_top
